// ### src/epi_pkg.sv
/*
  Shared constants and types of the external pin interrupt unit:
  register indexes, field positions, reset values, bus answers.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses equal to
  four times a register index.
*/
package epi_pkg;

  // ==========================================================
  // widths
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned LINE_COUNT = 18;
  localparam int unsigned GROUPS     = 3;
  localparam int unsigned REQS       = 4;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam logic [5:0] IDX_MASK_GROUP0  = 6'h27;
  localparam logic [5:0] IDX_MASK_GROUP1  = 6'h28;
  localparam logic [5:0] IDX_MASK_GROUP2  = 6'h29;
  localparam logic [5:0] IDX_CORE_CONTROL = 6'h35;
  localparam logic [5:0] IDX_IRQ_FLAGS    = 6'h3b;
  localparam logic [5:0] IDX_ENABLE_MASK  = 6'h3c;

  // ==========================================================
  // field positions: bits 6:3 shared by the enable mask and the flags, sense field in core control
  localparam int unsigned BIT_DEDICATED = 6;
  localparam int unsigned BIT_GROUP2    = 5;
  localparam int unsigned BIT_GROUP1    = 4;
  localparam int unsigned BIT_GROUP0    = 3;
  localparam int unsigned SENSE_LSB     = 0;

  // lines belonging to each pin-change group
  localparam logic [17:0] GROUP_SEL [3] = '{18'h000ff, 18'h00f00, 18'h3f000};

  // request slots: 0 dedicated pin, 1 + g for group g
  localparam int unsigned REQ_DEDICATED = 0;

  // ==========================================================
  // reset values and bus answers
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epi_sense_t;

endpackage : epi_pkg

// ### src/epi_sync.sv
/*
  Two-stage synchroniser bank for pin inputs.
  Assumes its inputs are asynchronous to clock_i; only the second
  stage is visible outside.
*/
`timescale 1ns/1ps
`default_nettype none

module epi_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock_i,  // system clock
  input  wire logic             rst_n_i,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_i,  // raw pin levels
  output logic      [WIDTH-1:0] sync_o    // synchronised levels
);

  // ==========================================================
  // stage one feeds stage two only, to let metastability settle
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end else begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule : epi_sync

`default_nettype wire

// ### src/epi_top.sv
/*
  External pin interrupt unit: one dedicated interrupt pin with a
  two-bit sense select and eighteen pin-change lines in three groups,
  with enable, per-line mask and flag registers on AXI4-Lite.
  Assumes pins are asynchronous; the global enable and the service
  acknowledges come from the CPU on clock_i.
*/
// Notes on behaviour
// - sense field selects low, any, fall or rise
// - pin synchronised first; pulses over one clock caught
// - dedicated request needs its enable and global enable
// - pin activity counts even when driven as output
// - group 2 lines 17:12 raise group 2 request
// - group 1 lines 11:8 raise group 1 request
// - group 0 lines 7:0 raise group 0 request
// - reserved bits always read zero
// - dedicated flag bit 6 set on trigger
// - flags clear on service or written one
// - dedicated flag reads zero in low-level mode
// - flag bit 5 set by group 2 change
// - flag bit 4 set by group 1 change
// - flag bit 3 set by group 0 change
// - line needs mask bit and group enable
// - pin changes detected on all eighteen lines
// - dedicated edges need the running clock

`timescale 1ns/1ps
`default_nettype none

module epi_top (
  input  wire logic        clock_i,              // system I/O clock, 200 MHz
  input  wire logic        rst_n_i,              // synchronous reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,       // write address
  input  wire logic        s_axi_awvalid_i,      // write address valid
  output logic             s_axi_awready_o,      // write address ready
  input  wire logic [31:0] s_axi_wdata_i,        // write data
  input  wire logic [3:0]  s_axi_wstrb_i,        // write byte strobes
  input  wire logic        s_axi_wvalid_i,       // write data valid
  output logic             s_axi_wready_o,       // write data ready
  output logic [1:0]       s_axi_bresp_o,        // write response
  output logic             s_axi_bvalid_o,       // write response valid
  input  wire logic        s_axi_bready_i,       // write response ready
  input  wire logic [7:0]  s_axi_araddr_i,       // read address
  input  wire logic        s_axi_arvalid_i,      // read address valid
  output logic             s_axi_arready_o,      // read address ready
  output logic [31:0]      s_axi_rdata_o,        // read data
  output logic [1:0]       s_axi_rresp_o,        // read response
  output logic             s_axi_rvalid_o,       // read data valid
  input  wire logic        s_axi_rready_i,       // read data ready
  // pins and CPU
  input  wire logic        dedicated_irq_pin_i,  // dedicated interrupt pin level
  input  wire logic [17:0] pin_change_line_i,    // pin-change line levels
  input  wire logic        global_irq_enable_i,  // global enable from status word
  input  wire logic [3:0]  service_ack_i,        // service routine entered, per slot
  output logic [3:0]       irq_request_o         // requests: 0 pin, 1..3 groups
);

  // ==========================================================
  // decode helper
  function automatic logic addr_hit(input logic [7:0] addr, input logic [5:0] idx);
    addr_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = addr_hit(addr, epi_pkg::IDX_MASK_GROUP0)
                | addr_hit(addr, epi_pkg::IDX_MASK_GROUP1)
                | addr_hit(addr, epi_pkg::IDX_MASK_GROUP2)
                | addr_hit(addr, epi_pkg::IDX_CORE_CONTROL)
                | addr_hit(addr, epi_pkg::IDX_IRQ_FLAGS)
                | addr_hit(addr, epi_pkg::IDX_ENABLE_MASK);
  endfunction : addr_mapped

  // ==========================================================
  // state
  logic [7:0]          mask_group0_reg;    // per-line masks 7:0
  logic [3:0]          mask_group1_reg;    // per-line masks 11:8
  logic [5:0]          mask_group2_reg;    // per-line masks 17:12
  logic                dedicated_en_reg;   // dedicated pin enable
  logic [2:0]          group_en_reg;       // group change enables
  epi_pkg::epi_sense_t sense_reg;          // dedicated pin sense select
  logic [3:0]          flag_reg;           // 0 pin, 1 + g for group g
  logic [3:0]          flag_next;
  logic [17:0]         line_prev_reg;      // previous synchronised lines
  logic                pin_prev_reg;       // previous synchronised pin
  logic [18:0]         pins_sync;
  logic [17:0]         line_sync;
  logic                pin_sync;

  // bus holding registers
  logic        aw_full_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic        wr_byte0;

  // ==========================================================
  // pin synchronisers; the pad level is used whatever the pin
  // direction, so software driving the pin can raise requests
  epi_sync #(
    .WIDTH (19)
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({dedicated_irq_pin_i, pin_change_line_i}),
    .sync_o  (pins_sync)
  );

  assign pin_sync  = pins_sync[18];
  assign line_sync = pins_sync[17:0];

  // previous samples for edge and change detection
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      line_prev_reg <= '0;
      pin_prev_reg  <= 1'b0;
    end else begin
      line_prev_reg <= line_sync;
      pin_prev_reg  <= pin_sync;
    end
  end

  // ==========================================================
  // event detection
  logic [17:0] masked_change;
  logic [2:0]  group_hit;
  logic        pin_event;

  // a line counts only while its own mask bit is set; sampling on the
  // clock means a change shorter than about one period may be missed
  assign masked_change = (line_sync ^ line_prev_reg)
                       & {mask_group2_reg, mask_group1_reg, mask_group0_reg};

  // one change detector per group
  generate
    for (genvar g = 0; g < 3; g++) begin : g_group
      assign group_hit[g] = |(masked_change & epi_pkg::GROUP_SEL[g]);
    end
  endgenerate

  // dedicated pin edge select; low level raises no flag
  always_comb begin
    unique case (sense_reg)
      epi_pkg::SENSE_LOW:  pin_event = 1'b0;
      epi_pkg::SENSE_ANY:  pin_event = pin_sync ^ pin_prev_reg;
      epi_pkg::SENSE_FALL: pin_event = !pin_sync && pin_prev_reg;
      epi_pkg::SENSE_RISE: pin_event = pin_sync && !pin_prev_reg;
    endcase
  end

  // ==========================================================
  // AXI4-Lite write channel handshakes
  assign aw_take  = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take   = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wr_byte0 = do_write && w_strb_reg[0];

  // address and data are taken in either order and held until both
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_full_reg     <= 1'b0;
      aw_addr_reg     <= '0;
      s_axi_awready_o <= 1'b1;
    end else if (aw_take) begin
      aw_full_reg     <= 1'b1;
      aw_addr_reg     <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (do_write) begin
      aw_full_reg     <= 1'b0;
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      w_full_reg     <= 1'b0;
      w_data_reg     <= '0;
      w_strb_reg     <= '0;
      s_axi_wready_o <= 1'b1;
    end else if (w_take) begin
      w_full_reg     <= 1'b1;
      w_data_reg     <= s_axi_wdata_i;
      w_strb_reg     <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (do_write) begin
      w_full_reg     <= 1'b0;
      s_axi_wready_o <= 1'b1;
    end
  end

  // write response; unmapped addresses answer with an error
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= epi_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= addr_mapped(aw_addr_reg) ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers; only byte lane 0 carries data
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mask_group0_reg <= epi_pkg::RST_BYTE;
      mask_group1_reg <= epi_pkg::RST_BYTE[3:0];
      mask_group2_reg <= epi_pkg::RST_BYTE[5:0];
    end else if (wr_byte0) begin
      if (addr_hit(aw_addr_reg, epi_pkg::IDX_MASK_GROUP0)) begin
        mask_group0_reg <= w_data_reg[7:0];
      end
      if (addr_hit(aw_addr_reg, epi_pkg::IDX_MASK_GROUP1)) begin
        mask_group1_reg <= w_data_reg[3:0];
      end
      if (addr_hit(aw_addr_reg, epi_pkg::IDX_MASK_GROUP2)) begin
        mask_group2_reg <= w_data_reg[5:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dedicated_en_reg <= epi_pkg::RST_BYTE[epi_pkg::BIT_DEDICATED];
      group_en_reg     <= epi_pkg::RST_BYTE[2:0];
      sense_reg        <= epi_pkg::SENSE_LOW;
    end else if (wr_byte0) begin
      if (addr_hit(aw_addr_reg, epi_pkg::IDX_ENABLE_MASK)) begin
        dedicated_en_reg <= w_data_reg[epi_pkg::BIT_DEDICATED];
        group_en_reg     <= w_data_reg[epi_pkg::BIT_GROUP2:epi_pkg::BIT_GROUP0];
      end
      if (addr_hit(aw_addr_reg, epi_pkg::IDX_CORE_CONTROL)) begin
        sense_reg <= epi_pkg::epi_sense_t'(w_data_reg[epi_pkg::SENSE_LSB +: 2]);
      end
    end
  end

  // ==========================================================
  // flags: cleared by a service acknowledge or a written one, but a
  // trigger in the same cycle wins so no event is lost
  logic [3:0] flag_clear;
  logic [3:0] flag_set;

  always_comb begin
    flag_clear = service_ack_i;
    if (wr_byte0 && addr_hit(aw_addr_reg, epi_pkg::IDX_IRQ_FLAGS)) begin
      flag_clear = flag_clear | {w_data_reg[epi_pkg::BIT_GROUP2],
                                 w_data_reg[epi_pkg::BIT_GROUP1],
                                 w_data_reg[epi_pkg::BIT_GROUP0],
                                 w_data_reg[epi_pkg::BIT_DEDICATED]};
    end
    flag_set  = {group_hit, pin_event};
    flag_next = (flag_reg & ~flag_clear) | flag_set;
    if (sense_reg == epi_pkg::SENSE_LOW) begin
      flag_next[epi_pkg::REQ_DEDICATED] = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flag_reg <= epi_pkg::RST_BYTE[3:0];
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ==========================================================
  // requests to the CPU; low level requests from the synchronised pin
  // for as long as it is held low, so the source must keep it there
  logic [3:0] req_next;

  always_comb begin
    if (sense_reg == epi_pkg::SENSE_LOW) begin
      req_next[0] = dedicated_en_reg && global_irq_enable_i && !pin_sync;
    end else begin
      req_next[0] = dedicated_en_reg && global_irq_enable_i && flag_reg[0];
    end
    req_next[3:1] = group_en_reg & flag_reg[3:1] & {3{global_irq_enable_i}};
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_request_o <= '0;
    end else begin
      irq_request_o <= req_next;
    end
  end

  // ==========================================================
  // read path; one read at a time, data registered at the take
  logic [7:0] read_byte;

  always_comb begin
    read_byte = 8'h00;  // reserved bits stay zero
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_MASK_GROUP0)) begin
      read_byte = mask_group0_reg;
    end
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_MASK_GROUP1)) begin
      read_byte[3:0] = mask_group1_reg;
    end
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_MASK_GROUP2)) begin
      read_byte[5:0] = mask_group2_reg;
    end
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_CORE_CONTROL)) begin
      read_byte[epi_pkg::SENSE_LSB +: 2] = sense_reg;
    end
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_ENABLE_MASK)) begin
      read_byte[epi_pkg::BIT_DEDICATED] = dedicated_en_reg;
      read_byte[epi_pkg::BIT_GROUP2:epi_pkg::BIT_GROUP0] = group_en_reg;
    end
    if (addr_hit(s_axi_araddr_i, epi_pkg::IDX_IRQ_FLAGS)) begin
      read_byte[epi_pkg::BIT_DEDICATED] = flag_reg[0];
      read_byte[epi_pkg::BIT_GROUP2:epi_pkg::BIT_GROUP0] = flag_reg[3:1];
    end
  end

  assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= epi_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= {24'h000000, read_byte};
      s_axi_rresp_o   <= addr_mapped(s_axi_araddr_i) ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end

endmodule : epi_top

`default_nettype wire

// ### test/epi_properties.sv
/*
  Concurrent checks on the pin interrupt unit, bound to epi_top.
  Assumes one clock domain and sees the top module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module epi_properties (
  input wire logic        clock_i,             // system clock
  input wire logic        rst_n_i,             // synchronous reset, active low
  input wire logic        s_axi_arready_o,     // read address ready
  input wire logic        s_axi_bvalid_o,      // write response valid
  input wire logic [31:0] s_axi_rdata_o,       // read data
  input wire logic [1:0]  s_axi_rresp_o,       // read response
  input wire logic        s_axi_rvalid_o,      // read data valid
  input wire logic [17:0] pin_change_line_i,   // line levels
  input wire logic        global_irq_enable_i, // global enable
  input wire logic [3:0]  service_ack_i,       // routine entered, per slot
  input wire logic [3:0]  irq_request_o        // requests
);
  // ==========================================================
  // helper: cycles since the lines last moved, saturating at 7
  logic [17:0] prev_line_reg;
  logic [2:0]  quiet_reg;

  always_ff @(posedge clock_i) begin
    prev_line_reg <= pin_change_line_i;
    if (!rst_n_i || pin_change_line_i != prev_line_reg) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // sequences; quiet lines rule out a flag set racing the clear
  sequence s_ack_quiet;
    service_ack_i[1] && quiet_reg >= 3'h6;
  endsequence
  sequence s_request_held;
    irq_request_o[3] && global_irq_enable_i && !s_axi_bvalid_o && !$past(service_ack_i[3]);
  endsequence

  // ==========================================================
  // assertions
  a_req_needs_global : assert property (
    !global_irq_enable_i |=> irq_request_o == 4'h0) else $error("request without global enable");
  a_ack_clears_group : assert property (
    s_ack_quiet |=> ##1 !irq_request_o[1]) else $error("group 0 request kept after service");
  a_request_stands : assert property (
    s_request_held |=> irq_request_o[3]) else $error("group 2 request dropped by itself");
  a_quiet_no_rise : assert property (
    quiet_reg >= 3'h6 && global_irq_enable_i && $past(global_irq_enable_i) && !s_axi_bvalid_o
    |=> !$rose(irq_request_o[2])) else $error("group 1 request rose without a line change");
  a_rdata_reserved_zero : assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0) else $error("reserved read bits not zero");
  a_slverr_data_zero : assert property (
    s_axi_rvalid_o && s_axi_rresp_o == 2'h2 |-> s_axi_rdata_o == 32'h0) else $error("error read gave data");
  a_reset_quiet : assert property (disable iff (1'b0)
    !rst_n_i |=> irq_request_o == 4'h0 && !s_axi_rvalid_o && !s_axi_bvalid_o) else $error("reset left activity");
  a_ready_after_reset : assert property (
    $rose(rst_n_i) |-> s_axi_arready_o) else $error("read address not ready after reset");
endmodule : epi_properties

bind epi_top epi_properties chk_u (.*);

`default_nettype wire

// ### test/epi_cpu_model.sv
/*
  Model of the CPU interrupt logic beside the unit: enters the routine
  of the lowest pending request after a set latency.
  Assumes requests are levels on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

module epi_cpu_model (
  input  wire logic       clock_i,       // system clock
  input  wire logic       rst_n_i,       // synchronous reset, active low
  input  wire logic       serve_en_i,    // answer requests while high
  input  wire logic [3:0] latency_i,     // cycles before entering a routine
  input  wire logic [3:0] irq_request_i, // requests from the unit
  output logic      [3:0] service_ack_o  // routine entered, one cycle
);
  // ==========================================================
  // after one pulse wait parks at 15 until requests drop, since the
  // request takes two edges to fall and must not be served twice
  logic [3:0] wait_reg;

  always_ff @(posedge clock_i) begin
    service_ack_o <= 4'h0;
    if (!rst_n_i || !serve_en_i || irq_request_i == 4'h0) wait_reg <= 4'h0;
    else if (wait_reg == latency_i) begin
      service_ack_o <= irq_request_i & (~irq_request_i + 4'h1);
      wait_reg      <= 4'hf;
    end
    else if (wait_reg != 4'hf) wait_reg <= wait_reg + 4'h1;
  end
endmodule : epi_cpu_model

`default_nettype wire

// ### test/epi_top_test.sv
/*
  Self-checking bench for the pin interrupt unit: AXI4-Lite tasks,
  pin stimulus and a CPU model that serves requests.
  Assumes epi_pkg, epi_top, the model and the checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none

module epi_top_test;
  // ==========================================================
  // signals, named as the unit's ports
  logic        clock_i = 1'b0;
  logic        rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, service_ack_i, irq_request_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        dedicated_irq_pin_i, global_irq_enable_i, serve_en;
  logic [17:0] pin_change_line_i;
  int          num_errors = 0;
  int          checked = 0;
  localparam logic [1:0] OK = epi_pkg::RESP_OKAY;
  localparam logic [5:0] FLAGS = epi_pkg::IDX_IRQ_FLAGS;
  localparam logic [5:0] ENABLE = epi_pkg::IDX_ENABLE_MASK;
  localparam logic [5:0] CORE = epi_pkg::IDX_CORE_CONTROL;
  logic [5:0]  idx_tab [6] = '{epi_pkg::IDX_MASK_GROUP0, epi_pkg::IDX_MASK_GROUP1, epi_pkg::IDX_MASK_GROUP2,
                               CORE, FLAGS, ENABLE};
  logic [7:0]  keep_tab [6] = '{8'hff, 8'h0f, 8'h3f, 8'h03, 8'h00, 8'h78};
  int          top_line [3] = '{7, 11, 17};

  always #2.5 clock_i = ~clock_i;

  epi_top dut_u (.*);

  epi_cpu_model cpu_u (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .serve_en_i    (serve_en),
    .latency_i     (4'h9),
    .irq_request_i (irq_request_o),
    .service_ack_o (service_ack_i)
  );

  // ==========================================================
  // tasks; each bus task lets an edge pass first so no strobe is set twice
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic axi_write(input logic [5:0] idx, input logic [7:0] data, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_awaddr_i  <= {idx, 2'b00};
    s_axi_wdata_i   <= {24'h0, data};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1 && n < 40);
    s_axi_bready_i <= 1'b0;
    check("write response", {30'h0, resp}, {30'h0, s_axi_bresp_o});
    if (s_axi_bvalid_o !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : axi_write

  task automatic axi_read(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_araddr_i  <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1 && n < 40);
    s_axi_rready_i <= 1'b0;
    check("read data", {24'h0, exp}, s_axi_rdata_o);
    check("read response", {30'h0, resp}, {30'h0, s_axi_rresp_o});
    if (s_axi_rvalid_o !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : axi_read

  task automatic wait_req(input int b, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (irq_request_o[b] !== v && n < 20);
    check("request", {31'h0, v}, {31'h0, irq_request_o[b]});
    if (irq_request_o[b] !== v) tally_and_finish();
  endtask : wait_req

  // ==========================================================
  // main sequence
  initial begin
    rst_n_i             <= 1'b0;
    s_axi_awvalid_i     <= 1'b0;
    s_axi_wvalid_i      <= 1'b0;
    s_axi_bready_i      <= 1'b0;
    s_axi_arvalid_i     <= 1'b0;
    s_axi_rready_i      <= 1'b0;
    s_axi_awaddr_i      <= 8'h00;
    s_axi_araddr_i      <= 8'h00;
    s_axi_wdata_i       <= 32'h0;
    s_axi_wstrb_i       <= 4'h1;
    dedicated_irq_pin_i <= 1'b0;
    pin_change_line_i   <= 18'h0;
    global_irq_enable_i <= 1'b0;
    serve_en            <= 1'b0;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    // reset values, writable bits, an unmapped place
    foreach (idx_tab[i]) axi_read(idx_tab[i], 8'h00, OK);
    foreach (idx_tab[i]) axi_write(idx_tab[i], 8'hff, OK);
    foreach (idx_tab[i]) axi_read(idx_tab[i], keep_tab[i], OK);
    // a write without byte lane 0 answers but changes nothing
    s_axi_wstrb_i <= 4'h0;
    axi_write(ENABLE, 8'h00, OK);
    s_axi_wstrb_i <= 4'h1;
    axi_read(ENABLE, 8'h78, OK);
    axi_write(6'h30, 8'hff, epi_pkg::RESP_SLVERR);
    axi_read(6'h30, 8'h00, epi_pkg::RESP_SLVERR);
    // top line of each group raises its flag and request; write one clears
    global_irq_enable_i <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      pin_change_line_i <= pin_change_line_i ^ (18'h1 << top_line[g]);
      wait_req(g + 1, 1'b1);
      axi_read(FLAGS, 8'(8'h08 << g), OK);
      axi_write(FLAGS, 8'(8'h08 << g), OK);
      wait_req(g + 1, 1'b0);
    end
    // masked line ignored; group disabled keeps the flag but no request
    axi_write(epi_pkg::IDX_MASK_GROUP0, 8'h01, OK);
    axi_write(ENABLE, 8'h00, OK);
    pin_change_line_i <= pin_change_line_i ^ 18'h2;
    repeat (8) @(posedge clock_i);
    axi_read(FLAGS, 8'h00, OK);
    pin_change_line_i <= pin_change_line_i ^ 18'h1;
    repeat (8) @(posedge clock_i);
    check("request", 32'h0, {28'h0, irq_request_o});
    axi_read(FLAGS, 8'h08, OK);
    axi_write(ENABLE, 8'h08, OK);
    wait_req(1, 1'b1);
    global_irq_enable_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check("request", 32'h0, {28'h0, irq_request_o});
    global_irq_enable_i <= 1'b1;
    wait_req(1, 1'b1);
    // the model enters the routine, which clears the flag
    serve_en <= 1'b1;
    wait_req(1, 1'b0);
    serve_en <= 1'b0;
    axi_read(FLAGS, 8'h00, OK);
    // edge senses: rising then falling step in each mode
    axi_write(ENABLE, 8'h40, OK);
    for (int s = 1; s < 4; s++) begin
      axi_write(CORE, 8'(s), OK);
      axi_write(FLAGS, 8'h40, OK);
      dedicated_irq_pin_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      axi_read(FLAGS, (s != 2) ? 8'h40 : 8'h00, OK);
      axi_write(FLAGS, 8'h40, OK);
      dedicated_irq_pin_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      axi_read(FLAGS, (s != 3) ? 8'h40 : 8'h00, OK);
    end
    // a two-cycle pulse is caught in rising mode
    dedicated_irq_pin_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    dedicated_irq_pin_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    axi_read(FLAGS, 8'h40, OK);
    // low level: request while low, flag reads clear
    axi_write(FLAGS, 8'h40, OK);
    axi_write(CORE, 8'h00, OK);
    wait_req(0, 1'b1);
    axi_read(FLAGS, 8'h00, OK);
    dedicated_irq_pin_i <= 1'b1; // low held across the steps above
    wait_req(0, 1'b0);
    tally_and_finish();
  end
endmodule : epi_top_test

`default_nettype wire
